// ### hw/gcra_regs.svh
// register offsets, field positions, reset values and timing counts
`ifndef GCRA_REGS_SVH
`define GCRA_REGS_SVH
// run-state index values behind the data port
`define GCRA_RUN_BANK_A 8'h01
`define GCRA_RUN_WDT 8'h03
`define GCRA_RUN_BANK_B 8'h05
`define GCRA_RUN_BANK_C 8'h06
`define GCRA_RUN_SPE1 8'h08
`define GCRA_RUN_SPE2 8'h09
`define GCRA_RUN_SPS1 8'h0A
`define GCRA_RUN_SPS2 8'h0B
// configuration-space offsets, logical unit eight
`define GCRA_CFG_BANK_A 8'hF6
`define GCRA_CFG_WDT 8'hF4
`define GCRA_CFG_BANK_B 8'hF9
`define GCRA_CFG_BANK_C 8'hFA
`define GCRA_CFG_SPE1 8'hB0
`define GCRA_CFG_SPE2 8'hB1
`define GCRA_CFG_SPS1 8'hB2
`define GCRA_CFG_SPS2 8'hB3
`define GCRA_CFG_PORT_BASE 8'hF2
`define GCRA_CFG_GINT1 8'hF7
`define GCRA_CFG_GINT2 8'hF8
`define GCRA_CFG_PIN_A 5'h1C
`define GCRA_CFG_PIN_B 5'h19
`define GCRA_CFG_PIN_C 5'h1A
// global space
`define GCRA_GLOB_RUN_CTRL 8'h03
`define GCRA_GLOB_RUN_BIT 7
// index port placements
`define GCRA_PORT_E0 8'hE0
`define GCRA_PORT_E2 8'hE2
`define GCRA_PORT_E4 8'hE4
`define GCRA_PORT_EA 8'hEA
`define GCRA_DATA_STEP 8'h01
`define GCRA_IO_HIGH 8'h00
// pin configuration fields
`define GCRA_PC_DIR 0
`define GCRA_PC_POL 1
`define GCRA_PC_FS_LO 3
`define GCRA_PC_FS_HI 4
`define GCRA_PC_IEN 5
`define GCRA_PC_OTYPE 7
`define GCRA_PINCFG_RESET 8'h01
`define GCRA_FSEL_ZERO 2'h0
`define GCRA_FSEL_TWO 2'h2
// group interrupt select fields
`define GCRA_GI_CH_LO 0
`define GCRA_GI_CH_HI 3
`define GCRA_GI_DEB 7
`define GCRA_GI_NONE 4'h0
// pin tables, bit = bank*8 + bit
`define GCRA_PIN_IMPL 24'hFF1DFF
`define GCRA_GPIO_AT_TWO 24'hFF1900
`define GCRA_GROUP1 24'h0000FF
`define GCRA_GROUP2 24'hFFFF00
`define GCRA_ALT_OUT_C0 24'h000000
`define GCRA_ALT_OUT_C1 24'hFF1DED
`define GCRA_ALT_OUT_C2 24'h000404
`define GCRA_ALT_OUT_C3 24'h1B0400
`define GCRA_ALT_OD_C1 24'h00000D
`define GCRA_ALT_OD_C3 24'h0B0400
`define GCRA_ALT_EITHER_EDGE_INTERRUPT_INPUT_C2 24'h000002
`define GCRA_ALT_EITHER_EDGE_INTERRUPT_INPUT_C3 24'h001804
`define GCRA_ALT_IDLE_C0 24'h000800
`define GCRA_NONE 24'h000000
// debounce time
`define GCRA_DEBOUNCE_MS 1
`define GCRA_CLK_KHZ 100000
`define GCRA_DEBOUNCE_CYCLES (`GCRA_DEBOUNCE_MS * `GCRA_CLK_KHZ)
`endif

// ### hw/gcra_pkg.sv
// types of the port configuration and run-state access block
package gcra_pkg;
  // register selected behind the data port
  typedef enum logic [3:0] {
    SEL_NONE, SEL_BANK_A, SEL_WDT, SEL_BANK_B, SEL_BANK_C,
    SEL_SPE1, SEL_SPE2, SEL_SPS1, SEL_SPS2
  } gcra_sel_t;
  // the whole state of the block
  typedef struct packed {
    logic [23:0] pin_meta;
    logic [23:0] pin_sync;
    logic [23:0][7:0] pin_cfg;
    logic [23:0] pin_data;
    logic [7:0] glob_ctrl;
    logic [7:0] base_prog;
    logic [7:0] base_act;
    logic [7:0] run_index;
    logic [7:0] wdt_ctrl;
    logic [1:0][7:0] sp_en;
    logic [1:0][7:0] sp_st;
    logic [1:0][7:0] gint_sel;
    logic [1:0][16:0] deb_cnt;
    logic [1:0] deb_out;
    logic [7:0] io_rdata;
    logic [7:0] cfg_rdata;
  } gcra_state_t;
endpackage

// ### hw/gcra_top.sv
// port configuration, pin drive and run-state index/data access
//
// Overview of operation
// [RQ1] run access needs global enable bit seven
// [RQ2] index port 0xEA, data 0xEB after reset
// [RQ3] index port placeable only at E0/E2/E4/EA
// [RQ4] data port sits at index port plus one
// [RQ5] new port placement used after leaving config
// [RQ6] host writes index, then accesses data port
// [RQ7] indexes 01, 05, 06 select bank data
// [RQ8] index 03 selects shared watchdog control
// [RQ9] indexes 08-0B select soft power registers
// [RQ10] same registers reachable in configuration space
// [RQ11] pin configuration only in configuration state
// [RQ12] config bits: direction, polarity, function, irq, type
// [RQ13] type bit picks open drain or push-pull
// [RQ14] plain port: direction 0 output, 1 input
// [RQ15] plain port polarity inverts both directions
// [RQ16] alternate function sets direction itself
// [RQ17] alternate outputs inverted, inputs not, except edge
// [RQ18] group irq is OR of enabled members
// [RQ19] group irqs also feed wake and event logic
// [RQ20] debounce rejects pulses of 1 ms or less
// [RQ21] unrouted alternate inputs held inactive
// [RQ22] reset makes every pin non-inverting input
// [RQ23] input reads pin, output reads last write
// [RQ24] codes 01-11 pick alternates, 00 default; pins in GPIO_AT_TWO use 10 as port and 00 as alternate
// [RQ25] unlisted indexes read zero, ignore writes
`timescale 1ns/1ps
`include "gcra_regs.svh"

module gcra_top #(
  parameter int P_DEBOUNCE_CYCLES = `GCRA_DEBOUNCE_CYCLES
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_clk_en,
  input wire logic i_cfg_state,
  input wire logic i_cfg_global,
  input wire logic [7:0] i_cfg_addr,
  input wire logic i_cfg_wr,
  input wire logic i_cfg_rd,
  input wire logic [7:0] i_cfg_wdata,
  output logic [7:0] o_cfg_rdata,
  input wire logic [15:0] i_io_addr,
  input wire logic i_io_wr,
  input wire logic i_io_rd,
  input wire logic [7:0] i_io_wdata,
  output logic [7:0] o_io_rdata,
  output logic o_io_hit,
  input wire logic [23:0] i_pin,
  output logic [23:0] o_pin,
  output logic [23:0] o_pin_oe,
  input wire logic [3:0][23:0] i_alt_out,
  output logic [3:0][23:0] o_alt_in,
  input wire logic [15:0] i_soft_power_event,
  output logic [15:0] o_soft_power_enable,
  output logic [15:0] o_soft_power_status,
  output logic [7:0] o_watchdog_control,
  output logic [1:0] o_group_irq,
  output logic [15:0] o_isa_irq
);

  localparam logic [3:0][23:0] ALT_OUT = {
    `GCRA_ALT_OUT_C3, `GCRA_ALT_OUT_C2, `GCRA_ALT_OUT_C1, `GCRA_ALT_OUT_C0
  };
  localparam logic [3:0][23:0] ALT_OD = {
    `GCRA_ALT_OD_C3, `GCRA_NONE, `GCRA_ALT_OD_C1, `GCRA_NONE
  };
  localparam logic [3:0][23:0] ALT_EITHER_EDGE_INTERRUPT_INPUT = {
    `GCRA_ALT_EITHER_EDGE_INTERRUPT_INPUT_C3, `GCRA_ALT_EITHER_EDGE_INTERRUPT_INPUT_C2, `GCRA_NONE, `GCRA_NONE
  };
  localparam logic [3:0][23:0] ALT_IDLE = {
    `GCRA_NONE, `GCRA_NONE, `GCRA_NONE, `GCRA_ALT_IDLE_C0
  };
  localparam logic [23:0] PIN_IMPL = `GCRA_PIN_IMPL;
  localparam logic [23:0] GPIO_AT_TWO = `GCRA_GPIO_AT_TWO;
  localparam logic [1:0][23:0] GROUP = {`GCRA_GROUP2, `GCRA_GROUP1};
  localparam logic [16:0] DEB_LIMIT = 17'(P_DEBOUNCE_CYCLES);

  gcra_pkg::gcra_state_t s_reg;
  gcra_pkg::gcra_state_t s_next;

  logic run_en;
  logic io_index_hit;
  logic io_data_hit;
  logic cfg_acc_wr;
  logic cfg_acc_rd;
  logic pin_hit;
  logic [4:0] pin_idx;
  gcra_pkg::gcra_sel_t run_sel;
  gcra_pkg::gcra_sel_t cfg_sel;
  logic [23:0] gpio_in;
  logic [23:0] rd_bits;
  logic [23:0] wr_mask;
  logic [23:0] int_src;
  logic [1:0] grp_raw;

  // run index to register
  function automatic gcra_pkg::gcra_sel_t gcra_run_sel(input logic [7:0] idx);
    unique case (idx)
      `GCRA_RUN_BANK_A: gcra_run_sel = gcra_pkg::SEL_BANK_A;
      `GCRA_RUN_WDT: gcra_run_sel = gcra_pkg::SEL_WDT;
      `GCRA_RUN_BANK_B: gcra_run_sel = gcra_pkg::SEL_BANK_B;
      `GCRA_RUN_BANK_C: gcra_run_sel = gcra_pkg::SEL_BANK_C;
      `GCRA_RUN_SPE1: gcra_run_sel = gcra_pkg::SEL_SPE1;
      `GCRA_RUN_SPE2: gcra_run_sel = gcra_pkg::SEL_SPE2;
      `GCRA_RUN_SPS1: gcra_run_sel = gcra_pkg::SEL_SPS1;
      `GCRA_RUN_SPS2: gcra_run_sel = gcra_pkg::SEL_SPS2;
      default: gcra_run_sel = gcra_pkg::SEL_NONE;
    endcase
  endfunction

  // configuration offset to the same register
  function automatic gcra_pkg::gcra_sel_t gcra_cfg_sel(input logic [7:0] adr);
    unique case (adr)
      `GCRA_CFG_BANK_A: gcra_cfg_sel = gcra_pkg::SEL_BANK_A;
      `GCRA_CFG_WDT: gcra_cfg_sel = gcra_pkg::SEL_WDT;
      `GCRA_CFG_BANK_B: gcra_cfg_sel = gcra_pkg::SEL_BANK_B;
      `GCRA_CFG_BANK_C: gcra_cfg_sel = gcra_pkg::SEL_BANK_C;
      `GCRA_CFG_SPE1: gcra_cfg_sel = gcra_pkg::SEL_SPE1;
      `GCRA_CFG_SPE2: gcra_cfg_sel = gcra_pkg::SEL_SPE2;
      `GCRA_CFG_SPS1: gcra_cfg_sel = gcra_pkg::SEL_SPS1;
      `GCRA_CFG_SPS2: gcra_cfg_sel = gcra_pkg::SEL_SPS2;
      default: gcra_cfg_sel = gcra_pkg::SEL_NONE;
    endcase
  endfunction

  // read value of a shared register
  function automatic logic [7:0] gcra_rd(
    input gcra_pkg::gcra_sel_t sel,
    input gcra_pkg::gcra_state_t st,
    input logic [23:0] bits
  );
    unique case (sel)
      gcra_pkg::SEL_BANK_A: gcra_rd = bits[7:0];
      gcra_pkg::SEL_BANK_B: gcra_rd = bits[15:8] & PIN_IMPL[15:8];
      gcra_pkg::SEL_BANK_C: gcra_rd = bits[23:16];
      gcra_pkg::SEL_WDT: gcra_rd = st.wdt_ctrl;
      gcra_pkg::SEL_SPE1: gcra_rd = st.sp_en[0];
      gcra_pkg::SEL_SPE2: gcra_rd = st.sp_en[1];
      gcra_pkg::SEL_SPS1: gcra_rd = st.sp_st[0];
      gcra_pkg::SEL_SPS2: gcra_rd = st.sp_st[1];
      gcra_pkg::SEL_NONE: gcra_rd = 8'h00; // RQ25
    endcase
  endfunction

  // write into a shared register
  function automatic gcra_pkg::gcra_state_t gcra_wr(
    input gcra_pkg::gcra_state_t st,
    input gcra_pkg::gcra_sel_t sel,
    input logic [7:0] d,
    input logic [23:0] wm
  );
    gcra_pkg::gcra_state_t r;
    r = st;
    unique case (sel)
      gcra_pkg::SEL_BANK_A:
        r.pin_data[7:0] = (st.pin_data[7:0] & ~wm[7:0]) | (d & wm[7:0]);
      gcra_pkg::SEL_BANK_B:
        r.pin_data[15:8] = (st.pin_data[15:8] & ~wm[15:8]) | (d & wm[15:8]);
      gcra_pkg::SEL_BANK_C:
        r.pin_data[23:16] = (st.pin_data[23:16] & ~wm[23:16]) | (d & wm[23:16]);
      gcra_pkg::SEL_WDT: r.wdt_ctrl = d; // RQ8
      gcra_pkg::SEL_SPE1: r.sp_en[0] = d;
      gcra_pkg::SEL_SPE2: r.sp_en[1] = d;
      gcra_pkg::SEL_SPS1: r.sp_st[0] = st.sp_st[0] & ~d;
      gcra_pkg::SEL_SPS2: r.sp_st[1] = st.sp_st[1] & ~d;
      gcra_pkg::SEL_NONE: r = st; // RQ25
    endcase
    gcra_wr = r;
  endfunction

  // run-state decode, live only outside configuration
  assign run_en = ~i_cfg_state & s_reg.glob_ctrl[`GCRA_GLOB_RUN_BIT]; // RQ1
  assign io_index_hit = run_en & (i_io_addr == {`GCRA_IO_HIGH, s_reg.base_act}); // RQ2
  assign io_data_hit = run_en
    & (i_io_addr == {`GCRA_IO_HIGH, s_reg.base_act + `GCRA_DATA_STEP}); // RQ4
  assign o_io_hit = (io_index_hit | io_data_hit) & (i_io_rd | i_io_wr);
  assign run_sel = gcra_run_sel(s_reg.run_index); // RQ7 RQ9

  // configuration decode
  assign cfg_acc_wr = i_cfg_state & i_cfg_wr; // RQ11
  assign cfg_acc_rd = i_cfg_state & i_cfg_rd;
  assign cfg_sel = gcra_cfg_sel(i_cfg_addr); // RQ10
  assign pin_idx = (i_cfg_addr[7:3] == `GCRA_CFG_PIN_A) ? {2'h0, i_cfg_addr[2:0]}
    : (i_cfg_addr[7:3] == `GCRA_CFG_PIN_B) ? {2'h1, i_cfg_addr[2:0]}
    : {2'h2, i_cfg_addr[2:0]};
  assign pin_hit = ~i_cfg_global & PIN_IMPL[pin_idx]
    & ((i_cfg_addr[7:3] == `GCRA_CFG_PIN_A) | (i_cfg_addr[7:3] == `GCRA_CFG_PIN_B)
    | (i_cfg_addr[7:3] == `GCRA_CFG_PIN_C));

  // per-pin function, direction, polarity and drive
  genvar g;
  genvar c;
  generate
    for (g = 0; g < 24; g++)
    begin : g_pin
      logic [7:0] cfg;
      logic [1:0] fsel;
      logic pol;
      logic gpio;
      logic drive;
      logic val;
      logic od;
      assign cfg = s_reg.pin_cfg[g];
      assign fsel = cfg[`GCRA_PC_FS_HI:`GCRA_PC_FS_LO]; // RQ12
      assign pol = cfg[`GCRA_PC_POL];
      assign gpio = (fsel == (GPIO_AT_TWO[g] ? `GCRA_FSEL_TWO : `GCRA_FSEL_ZERO)); // RQ24
      assign drive = PIN_IMPL[g] & (gpio ? ~cfg[`GCRA_PC_DIR] : ALT_OUT[fsel][g]); // RQ14 RQ16
      assign val = (gpio ? s_reg.pin_data[g] : i_alt_out[fsel][g]) ^ pol; // RQ15 RQ17
      assign od = cfg[`GCRA_PC_OTYPE] & (gpio | ALT_OD[fsel][g]); // RQ13
      assign o_pin[g] = val & ~od;
      assign o_pin_oe[g] = drive & (~od | ~val);
      assign gpio_in[g] = gpio & cfg[`GCRA_PC_DIR];
      // input reads the pin, output reads the stored bit
      assign rd_bits[g] = gpio_in[g] ? (s_reg.pin_sync[g] ^ pol) : s_reg.pin_data[g]; // RQ23
      assign wr_mask[g] = PIN_IMPL[g] & ~gpio_in[g]; // RQ23
      // interrupt source follows polarity for port and edge input only
      assign int_src[g] = cfg[`GCRA_PC_IEN]
        & (s_reg.pin_sync[g] ^ (pol & (gpio | ALT_EITHER_EDGE_INTERRUPT_INPUT[fsel][g]))); // RQ17
      for (c = 0; c < 4; c++)
      begin : g_alt
        // alternate inputs, idle when not routed here
        assign o_alt_in[c][g] = (fsel == 2'(c) && !gpio && !ALT_OUT[c][g])
          ? (s_reg.pin_sync[g] ^ (pol & ALT_EITHER_EDGE_INTERRUPT_INPUT[c][g]))
          : ALT_IDLE[c][g]; // RQ21
      end
    end
  endgenerate

  // group OR of enabled members
  assign grp_raw[0] = |(int_src & GROUP[0]); // RQ18
  assign grp_raw[1] = |(int_src & GROUP[1]); // RQ18

  // next-state logic
  always_comb
  begin
    s_next = s_reg;
    s_next.pin_meta = i_pin;
    s_next.pin_sync = s_reg.pin_meta;
    // placement moves to the decoder outside configuration
    if (!i_cfg_state)
    begin
      s_next.base_act = s_reg.base_prog; // RQ5
    end
    // configuration writes
    if (cfg_acc_wr)
    begin
      if (i_cfg_global)
      begin
        if (i_cfg_addr == `GCRA_GLOB_RUN_CTRL)
        begin
          s_next.glob_ctrl = i_cfg_wdata; // RQ1
        end
      end
      else if (pin_hit)
      begin
        s_next.pin_cfg[pin_idx] = i_cfg_wdata; // RQ11 RQ12
      end
      else if (i_cfg_addr == `GCRA_CFG_PORT_BASE)
      begin
        if ((i_cfg_wdata == `GCRA_PORT_E0) || (i_cfg_wdata == `GCRA_PORT_E2)
          || (i_cfg_wdata == `GCRA_PORT_E4) || (i_cfg_wdata == `GCRA_PORT_EA))
        begin
          s_next.base_prog = i_cfg_wdata; // RQ3
        end
      end
      else if (i_cfg_addr == `GCRA_CFG_GINT1)
      begin
        s_next.gint_sel[0] = i_cfg_wdata;
      end
      else if (i_cfg_addr == `GCRA_CFG_GINT2)
      begin
        s_next.gint_sel[1] = i_cfg_wdata;
      end
      else
      begin
        s_next = gcra_wr(s_next, cfg_sel, i_cfg_wdata, wr_mask); // RQ10
      end
    end
    // run-state index and data writes
    if (io_index_hit && i_io_wr)
    begin
      s_next.run_index = i_io_wdata; // RQ6
    end
    if (io_data_hit && i_io_wr)
    begin
      s_next = gcra_wr(s_next, run_sel, i_io_wdata, wr_mask); // RQ7 RQ8 RQ9
    end
    // event sets win over a same-cycle clear
    s_next.sp_st = s_next.sp_st | i_soft_power_event;
    // debounce per group
    for (int k = 0; k < 2; k++)
    begin
      if (!s_reg.gint_sel[k][`GCRA_GI_DEB])
      begin
        s_next.deb_out[k] = grp_raw[k];
        s_next.deb_cnt[k] = '0;
      end
      else if (grp_raw[k] == s_reg.deb_out[k])
      begin
        s_next.deb_cnt[k] = '0;
      end
      else if (s_reg.deb_cnt[k] >= DEB_LIMIT)
      begin
        s_next.deb_out[k] = grp_raw[k]; // RQ20
        s_next.deb_cnt[k] = '0;
      end
      else
      begin
        s_next.deb_cnt[k] = s_reg.deb_cnt[k] + 17'h00001;
      end
    end
    // run-state read data
    if (io_data_hit && i_io_rd)
    begin
      s_next.io_rdata = gcra_rd(run_sel, s_reg, rd_bits); // RQ7 RQ8 RQ9 RQ25
    end
    else if (io_index_hit && i_io_rd)
    begin
      s_next.io_rdata = s_reg.run_index;
    end
    // configuration read data
    if (cfg_acc_rd)
    begin
      if (i_cfg_global)
      begin
        s_next.cfg_rdata = (i_cfg_addr == `GCRA_GLOB_RUN_CTRL) ? s_reg.glob_ctrl : 8'h00;
      end
      else if (pin_hit)
      begin
        s_next.cfg_rdata = s_reg.pin_cfg[pin_idx]; // RQ11
      end
      else if (i_cfg_addr == `GCRA_CFG_PORT_BASE)
      begin
        s_next.cfg_rdata = s_reg.base_prog;
      end
      else if (i_cfg_addr == `GCRA_CFG_GINT1)
      begin
        s_next.cfg_rdata = s_reg.gint_sel[0];
      end
      else if (i_cfg_addr == `GCRA_CFG_GINT2)
      begin
        s_next.cfg_rdata = s_reg.gint_sel[1];
      end
      else
      begin
        s_next.cfg_rdata = gcra_rd(cfg_sel, s_reg, rd_bits); // RQ10
      end
    end
  end

  // state register, frozen while clock enable is low
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      s_reg <= '0;
      s_reg.pin_cfg <= {24{`GCRA_PINCFG_RESET}}; // RQ22
      s_reg.base_prog <= `GCRA_PORT_EA; // RQ2
      s_reg.base_act <= `GCRA_PORT_EA; // RQ2
    end
    else if (i_clk_en)
    begin
      s_reg <= s_next;
    end
  end

  // group interrupts onto the chosen isa channel
  always_comb
  begin
    o_isa_irq = 16'h0000;
    for (int n = 0; n < 2; n++)
    begin
      if (s_reg.gint_sel[n][`GCRA_GI_CH_HI:`GCRA_GI_CH_LO] != `GCRA_GI_NONE)
      begin
        o_isa_irq[s_reg.gint_sel[n][`GCRA_GI_CH_HI:`GCRA_GI_CH_LO]] =
          o_isa_irq[s_reg.gint_sel[n][`GCRA_GI_CH_HI:`GCRA_GI_CH_LO]]
          | s_reg.deb_out[n]; // RQ18
      end
    end
  end

  // register-fed outputs
  assign o_group_irq = s_reg.deb_out; // RQ19
  assign o_io_rdata = s_reg.io_rdata;
  assign o_cfg_rdata = s_reg.cfg_rdata;
  assign o_watchdog_control = s_reg.wdt_ctrl;
  assign o_soft_power_enable = s_reg.sp_en;
  assign o_soft_power_status = s_reg.sp_st;

endmodule

// ### tb/gcra_board.sv
// board side of the port pins, with released pads held at a board level
`timescale 1ns/1ps
module gcra_board (
  input wire logic [23:0] i_drive,
  input wire logic [23:0] i_oe,
  input wire logic [23:0] i_level,
  output logic [23:0] o_pad
);
  // a driven pad follows the device, a released one the board level
  assign o_pad = (i_drive & i_oe) | (i_level & ~i_oe);
endmodule

// ### tb/gcra_chk.sv
// checker for run-state port access and pin drive of the port block
`timescale 1ns/1ps
module gcra_chk (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_clk_en,
  input wire logic i_cfg_state,
  input wire logic i_cfg_global,
  input wire logic [7:0] i_cfg_addr,
  input wire logic i_cfg_wr,
  input wire logic i_cfg_rd,
  input wire logic [7:0] i_cfg_wdata,
  input wire logic [7:0] o_cfg_rdata,
  input wire logic [15:0] i_io_addr,
  input wire logic i_io_wr,
  input wire logic i_io_rd,
  input wire logic [7:0] o_io_rdata,
  input wire logic o_io_hit,
  input wire logic [23:0] o_pin_oe,
  input wire logic [15:0] i_soft_power_event,
  input wire logic [15:0] o_soft_power_status,
  input wire logic [7:0] o_watchdog_control,
  input wire logic [1:0] o_group_irq,
  input wire logic [15:0] o_isa_irq
);
  logic run_en_reg;
  logic touched_reg;
  logic moved_reg;
  // shadow of run enable, any configuration write and port move
  always_ff @(posedge i_sys_clk or posedge i_rst)
    if (i_rst)
    begin
      run_en_reg <= 1'b0;
      touched_reg <= 1'b0;
      moved_reg <= 1'b0;
    end
    else if (i_clk_en && i_cfg_state && i_cfg_wr)
    begin
      touched_reg <= 1'b1;
      if (i_cfg_global && i_cfg_addr == 8'h03)
        run_en_reg <= i_cfg_wdata[7];
      if (!i_cfg_global && i_cfg_addr == 8'hF2 && i_cfg_wdata inside {8'hE0, 8'hE2, 8'hE4})
        moved_reg <= 1'b1;
    end

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  // index write at the reset placement
  sequence ea_write;
    i_clk_en && !i_cfg_state && run_en_reg && !moved_reg && i_io_wr && i_io_addr == 16'h00EA;
  endsequence
  // soft power event pulse
  sequence sp_event;
    i_clk_en && i_soft_power_event != 16'h0000;
  endsequence

  run_gate_a: assert property (!run_en_reg |-> !o_io_hit)
    else $error("port hit with run access off");
  default_port_a: assert property (ea_write |-> o_io_hit)
    else $error("index port not at reset place");
  cfg_quiet_a: assert property (i_cfg_state |-> !o_io_hit)
    else $error("port hit in config state");
  port_place_a: assert property (o_io_hit |-> i_io_addr[15:4] == 12'h00E &&
    i_io_addr[3:0] inside {4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'hA, 4'hB})
    else $error("port hit at illegal address");
  io_answer_a: assert property ($changed(o_io_rdata) |-> $past(o_io_hit && i_io_rd))
    else $error("run read data moved without read");
  cfg_answer_a: assert property ($changed(o_cfg_rdata) |->
    $past(i_clk_en && i_cfg_state && i_cfg_rd))
    else $error("config read data moved without read");
  wdt_write_a: assert property ($changed(o_watchdog_control) |->
    $past(i_clk_en && (i_cfg_wr && i_cfg_state || i_io_wr && o_io_hit)))
    else $error("watchdog control moved without write");
  sp_set_a: assert property (sp_event |=>
    (o_soft_power_status & $past(i_soft_power_event)) == $past(i_soft_power_event))
    else $error("soft power event lost");
  reset_input_a: assert property (!touched_reg |-> o_pin_oe == 24'h000000)
    else $error("pin driven before setup");
  irq_route_a: assert property (o_group_irq == 2'b00 |-> o_isa_irq == 16'h0000)
    else $error("bus irq without group irq");
endmodule

// ### tb/testbench.sv
// self-checking bench for the port configuration and run-state access block
`timescale 1ns/1ps
module testbench;
  logic i_sys_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_clk_en = 1'b1;
  logic i_cfg_state = 1'b0, i_cfg_global = 1'b0, i_cfg_wr = 1'b0, i_cfg_rd = 1'b0;
  logic [7:0] i_cfg_addr = 8'h00, i_cfg_wdata = 8'h00, i_io_wdata = 8'h00;
  logic [7:0] o_cfg_rdata, o_io_rdata, o_watchdog_control, d;
  logic [15:0] i_io_addr = 16'h0000, i_soft_power_event = 16'h0000;
  logic [15:0] o_soft_power_enable, o_soft_power_status, o_isa_irq;
  logic i_io_wr = 1'b0, i_io_rd = 1'b0, o_io_hit, h;
  logic [23:0] i_pin, o_pin, o_pin_oe;
  logic [23:0] lvl = 24'h000002;
  logic [3:0][23:0] i_alt_out = 96'h0, o_alt_in;
  logic [1:0] o_group_irq;
  int miscompares = 0;
  int num_checks = 0;

  gcra_top #(.P_DEBOUNCE_CYCLES(8)) uut (
    .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_clk_en(i_clk_en), .i_cfg_state(i_cfg_state),
    .i_cfg_global(i_cfg_global), .i_cfg_addr(i_cfg_addr), .i_cfg_wr(i_cfg_wr),
    .i_cfg_rd(i_cfg_rd), .i_cfg_wdata(i_cfg_wdata), .o_cfg_rdata(o_cfg_rdata),
    .i_io_addr(i_io_addr), .i_io_wr(i_io_wr), .i_io_rd(i_io_rd), .i_io_wdata(i_io_wdata),
    .o_io_rdata(o_io_rdata), .o_io_hit(o_io_hit), .i_pin(i_pin), .o_pin(o_pin),
    .o_pin_oe(o_pin_oe), .i_alt_out(i_alt_out), .o_alt_in(o_alt_in),
    .i_soft_power_event(i_soft_power_event), .o_soft_power_enable(o_soft_power_enable),
    .o_soft_power_status(o_soft_power_status), .o_watchdog_control(o_watchdog_control),
    .o_group_irq(o_group_irq), .o_isa_irq(o_isa_irq)
  );
  gcra_board board (.i_drive(o_pin), .i_oe(o_pin_oe), .i_level(lvl), .o_pad(i_pin));

  // free-running clock
  always #5 i_sys_clk = ~i_sys_clk;

  // report counts and verdict
  task automatic wrap_up();
    $display("checks %0d, miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // compare one byte
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // config state level, changed at an edge
  task automatic set_cfg(input logic v);
    @(posedge i_sys_clk);
    i_cfg_state <= v;
  endtask

  // config write, taken at the second edge
  task automatic cfg_wr(input logic g, input logic [7:0] a, input logic [7:0] v);
    @(posedge i_sys_clk);
    i_cfg_global <= g;
    i_cfg_addr <= a;
    i_cfg_wdata <= v;
    i_cfg_wr <= 1'b1;
    @(posedge i_sys_clk);
    i_cfg_wr <= 1'b0;
  endtask

  // config read of the unit space
  task automatic cfg_rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge i_sys_clk);
    i_cfg_global <= 1'b0;
    i_cfg_addr <= a;
    i_cfg_rd <= 1'b1;
    @(posedge i_sys_clk);
    i_cfg_rd <= 1'b0;
    #1 v = o_cfg_rdata;
  endtask

  // run-state port access; the hit is checked while the strobe is up
  task automatic io(input logic [7:0] a, input logic wr, input logic [7:0] v,
                    input logic eh, output logic [7:0] r);
    @(posedge i_sys_clk);
    i_io_addr <= {8'h00, a};
    i_io_wdata <= v;
    i_io_wr <= wr;
    i_io_rd <= ~wr;
    #1 chk({7'h00, o_io_hit}, {7'h00, eh});
    @(posedge i_sys_clk);
    i_io_wr <= 1'b0;
    i_io_rd <= 1'b0;
    #1 r = o_io_rdata;
  endtask

  // bounded wait for group one to reach a level
  task automatic wait_irq(input logic lv, input int n);
    int k;
    k = 0;
    while (o_group_irq[0] !== lv && k < n)
    begin
      @(posedge i_sys_clk);
      #1;
      k++;
    end
    chk({7'h00, o_group_irq[0]}, {7'h00, lv});
    if (o_group_irq[0] !== lv)
      wrap_up();
  endtask

  // main sequence
  initial
  begin
    repeat (20) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    io(8'hEA, 1'b1, 8'h01, 1'b0, d);
    chk({7'h00, |o_pin_oe}, 8'h00);
    set_cfg(1'b1);
    cfg_rd(8'hE0, d);
    chk(d, 8'h01);
    cfg_wr(1'b1, 8'h03, 8'h80);
    io(8'hEA, 1'b1, 8'h01, 1'b0, d);
    cfg_wr(1'b0, 8'hF2, 8'hE6);
    cfg_rd(8'hF2, d);
    chk(d, 8'hEA);
    cfg_wr(1'b0, 8'hE0, 8'h00);
    cfg_wr(1'b0, 8'hE1, 8'h03);
    cfg_wr(1'b0, 8'hE2, 8'h80);
    cfg_wr(1'b0, 8'hE3, 8'h0B);
    cfg_wr(1'b0, 8'hE4, 8'h21);
    cfg_wr(1'b0, 8'hCA, 8'h18);
    cfg_wr(1'b0, 8'hCB, 8'h11);
    cfg_wr(1'b0, 8'hF7, 8'h05);
    cfg_rd(8'hE3, d);
    chk(d, 8'h0B);
    set_cfg(1'b0);
    io(8'hEA, 1'b1, 8'h01, 1'b1, d);
    io(8'hEB, 1'b1, 8'hF5, 1'b1, d);
    io(8'hEB, 1'b0, 8'h00, 1'b1, d);
    chk(d & 8'hF7, 8'h05);
    chk(o_pin_oe[7:0], 8'h09);
    chk(o_pin[7:0] & o_pin_oe[7:0], 8'h09);
    chk({7'h00, o_alt_in[0][11]}, 8'h01);
    io(8'hEB, 1'b1, 8'h00, 1'b1, d);
    chk(o_pin_oe[7:0], 8'h0D);
    chk(o_pin[7:0] & o_pin_oe[7:0], 8'h08);
    @(posedge i_sys_clk);
    i_alt_out[1][3] <= 1'b1;
    i_alt_out[3][10] <= 1'b1;
    lvl <= 24'h000802;
    @(posedge i_sys_clk);
    #1 chk(o_pin[7:0] & o_pin_oe[7:0], 8'h00);
    chk({6'h00, o_pin_oe[10], o_pin[10]}, 8'h03);
    cfg_wr(1'b0, 8'hE0, 8'h01);
    for (int i = 0; i < 16; i++)
      if (i != 1 && i != 5 && i != 6)
      begin
        io(8'hEA, 1'b1, 8'(i), 1'b1, d);
        io(8'hEB, 1'b1, 8'hA5, 1'b1, d);
        io(8'hEB, 1'b0, 8'h00, 1'b1, d);
        chk(d, (i == 3 || i == 8 || i == 9) ? 8'hA5 : 8'h00);
      end
    chk(o_watchdog_control, 8'hA5);
    chk(o_soft_power_enable[15:8], 8'hA5);
    @(posedge i_sys_clk);
    i_clk_en <= 1'b0;
    io(8'hEA, 1'b1, 8'h03, 1'b1, d);
    @(posedge i_sys_clk);
    i_clk_en <= 1'b1;
    io(8'hEA, 1'b0, 8'h00, 1'b1, d);
    chk(d, 8'h0F);
    io(8'hEA, 1'b1, 8'h05, 1'b1, d);
    io(8'hEB, 1'b0, 8'h00, 1'b1, d);
    chk(d & 8'h08, 8'h08);
    @(posedge i_sys_clk);
    i_soft_power_event <= 16'h0102;
    @(posedge i_sys_clk);
    i_soft_power_event <= 16'h0000;
    io(8'hEA, 1'b1, 8'h0B, 1'b1, d);
    io(8'hEB, 1'b0, 8'h00, 1'b1, d);
    chk(d, 8'h01);
    chk(o_soft_power_status[7:0], 8'h02);
    io(8'hEB, 1'b1, 8'h01, 1'b1, d);
    chk(o_soft_power_status[15:8], 8'h00);
    set_cfg(1'b1);
    cfg_rd(8'hF4, d);
    chk(d, 8'hA5);
    cfg_rd(8'hE0, d);
    chk(d, 8'h00);
    cfg_wr(1'b0, 8'hF2, 8'hE4);
    set_cfg(1'b0);
    io(8'hEA, 1'b1, 8'h01, 1'b0, d);
    io(8'hE4, 1'b1, 8'h01, 1'b1, d);
    io(8'hE5, 1'b0, 8'h00, 1'b1, d);
    @(posedge i_sys_clk);
    lvl[4] <= 1'b1;
    wait_irq(1'b1, 10);
    chk(o_isa_irq[7:0], 8'h20);
    @(posedge i_sys_clk);
    lvl[4] <= 1'b0;
    wait_irq(1'b0, 10);
    set_cfg(1'b1);
    cfg_wr(1'b0, 8'hF7, 8'h85);
    @(posedge i_sys_clk);
    lvl[4] <= 1'b1;
    repeat (8) @(posedge i_sys_clk);
    lvl[4] <= 1'b0;
    h = 1'b0;
    repeat (30)
    begin
      @(posedge i_sys_clk);
      h = h | o_group_irq[0];
    end
    chk({7'h00, h}, 8'h00);
    lvl[4] <= 1'b1;
    wait_irq(1'b1, 30);
    wrap_up();
  end
endmodule

bind gcra_top gcra_chk chk (
  .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_clk_en(i_clk_en), .i_cfg_state(i_cfg_state),
  .i_cfg_global(i_cfg_global), .i_cfg_addr(i_cfg_addr), .i_cfg_wr(i_cfg_wr),
  .i_cfg_rd(i_cfg_rd), .i_cfg_wdata(i_cfg_wdata), .o_cfg_rdata(o_cfg_rdata),
  .i_io_addr(i_io_addr), .i_io_wr(i_io_wr), .i_io_rd(i_io_rd), .o_io_rdata(o_io_rdata),
  .o_io_hit(o_io_hit), .o_pin_oe(o_pin_oe), .i_soft_power_event(i_soft_power_event),
  .o_soft_power_status(o_soft_power_status), .o_watchdog_control(o_watchdog_control),
  .o_group_irq(o_group_irq), .o_isa_irq(o_isa_irq)
);
